// >>> verilog/wsc_regs.svh
// Register offsets, field positions, reset values and the base address window
// for the wake and system-bus configuration register bank.
// Assumes inclusion by bare name from the register bank design file.
// Function
// - F0 bit 0 reports the slow clock input as absent (1) or present (0).
// - F0 bit 1 turns the wake-on-key logic off when one; zero keeps it on.
// - While that logic is off, its 32 kHz clock is blocked from reaching it.
// - Steering 00 lets parallel port mode bits govern floppy; select pin ignored.
// - Steering 01 with select pin low: drive 0 dedicated, drive 1 on port.
// - Steering 10 with pin low puts both drives on port; 11 is reserved.
// - Base address is hi[3:0] to bits 11:8, lo[7:3] to 7:3, rest zero.
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define WSC_IDX_SMB_HIGH 8'h60
`define WSC_IDX_SMB_LOW 8'h61
`define WSC_IDX_SLOW_CLK 8'hf0
`define WSC_IDX_STEER 8'hf1

`define WSC_BIT_ABSENT 0
`define WSC_BIT_KEY_OFF 1
`define WSC_STEER_LSB 0
`define WSC_STEER_MSB 1
`define WSC_HIGH_MSB 3
`define WSC_LOW_LSB 3

`define WSC_RST_SMB_HIGH 8'h00
`define WSC_RST_SMB_LOW 8'h00
`define WSC_RST_SLOW_CLK 8'h00
`define WSC_RST_STEER 8'h00

// Programmable base address window that software must stay inside.
`define WSC_BASE_MIN 16'h0100
`define WSC_BASE_MAX 16'h0ff8

`endif

// >>> verilog/wsc_pkg.sv
// Types shared by the register bank and its clock gate.
// Assumes the constants header is on the include path.
`default_nettype none

package wsc_pkg;

	typedef enum logic [1:0] {
		WSC_STEER_MODE_BITS = 2'b00,
		WSC_STEER_PIN_SPLIT = 2'b01,
		WSC_STEER_PIN_BOTH = 2'b10,
		WSC_STEER_RESERVED = 2'b11
	} wsc_steer_type;

	// Classic bus request from the master.
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [11:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wsc_wb_req_type;

	// Slave answer.
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wsc_wb_rsp_type;

	// Floppy drive placement seen by the port multiplexers.
	typedef struct packed {
		logic floppy_on_port;
		logic drive0_on_port;
		logic drive1_on_port;
	} wsc_route_type;

endpackage

`default_nettype wire

// >>> verilog/wsc_clk_gate.sv
// Gate for the 32 kHz clock that feeds the wake-on-key logic.
// Assumes slow_clock_input is sampled as a synchronous level on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module wsc_clk_gate (
	input wire logic ref_clk, // System clock.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic slow_clock_input, // Raw 32 kHz input level.
	input wire logic gate_on, // High lets the slow clock through.
	output logic gated_slow_clock // Slow clock as seen by the key logic.
);
	import wsc_pkg::*;

	typedef struct packed {
		logic out;
	} wsc_gate_state_type;

	wsc_gate_state_type state_q, state_d;

	// The gate is a flop, not an AND gate, so turning it off mid-phase
	// cannot cut a runt pulse onto the key logic's clock.
	always_comb begin
		state_d = state_q;
		state_d.out = slow_clock_input & gate_on;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign gated_slow_clock = state_q.out;

endmodule

`default_nettype wire

// >>> verilog/wsc_top.sv
// Configuration register bank for the wake runtime logic and the
// system-bus controller base address, reached over classic Wishbone.
// Assumes one clock, a synchronous active-low reset, and that all pin
// inputs are already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "wsc_regs.svh"

module wsc_top (
	input wire logic ref_clk, // 20 MHz system clock.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic wb_cyc_i, // Bus cycle.
	input wire logic wb_stb_i, // Bus strobe.
	input wire logic wb_we_i, // Write when high.
	input wire logic [11:0] wb_adr_i, // Byte address.
	input wire logic [3:0] wb_sel_i, // Byte lane selects.
	input wire logic [31:0] wb_dat_i, // Write data.
	output logic wb_ack_o, // Acknowledge.
	output logic [31:0] wb_dat_o, // Read data.
	input wire logic slow_clock_input, // 32 kHz clock pin level.
	input wire logic floppy_port_select_pin, // External select, low active.
	input wire logic [1:0] pp_mode_drive_on_port, // Mode bits, per drive.
	output logic slow_clock_absent_flag, // Software says no slow clock.
	output logic wake_key_logic_off, // Wake-on-key logic disabled.
	output logic gated_slow_clock, // Slow clock to wake-on-key logic.
	output logic floppy_on_port, // Floppy uses parallel port pins.
	output logic drive0_on_port, // Drive 0 on parallel port pins.
	output logic drive1_on_port, // Drive 1 on parallel port pins.
	output logic [15:0] smbus_base_addr, // Decoded base address.
	output logic smbus_base_in_range // Base inside the legal window.
);
	import wsc_pkg::*;

	typedef struct packed {
		wsc_wb_rsp_type rsp;
		logic absent;
		logic key_off;
		wsc_steer_type steer;
		logic [3:0] base_high;
		logic [4:0] base_low;
		logic [15:0] base;
		logic base_ok;
		wsc_route_type route;
	} wsc_state_type;

	wsc_state_type state_q, state_d;
	wsc_wb_req_type req;
	logic [7:0] idx;
	logic addr_ok;
	logic access;
	logic wr_byte0;
	logic [15:0] base_next;

	// Reset bytes kept whole so the field slices below stay tied to them.
	localparam logic [7:0] rst_slow_clk = `WSC_RST_SLOW_CLK;
	localparam logic [7:0] rst_steer = `WSC_RST_STEER;
	localparam logic [7:0] rst_smb_high = `WSC_RST_SMB_HIGH;
	localparam logic [7:0] rst_smb_low = `WSC_RST_SMB_LOW;

	// Assembles the bus-visible base; only the programmable bits survive.
	function automatic logic [15:0] base_of(
		input logic [3:0] high,
		input logic [4:0] low
	);
		base_of = {4'h0, high, low, 3'h0};
	endfunction

	// Checks a register index against one wanted register index.
	function automatic logic hit(
		input logic [7:0] index,
		input logic [7:0] want
	);
		hit = (index == want);
	endfunction

	// Drive placement for a steering mode and the select pin level.
	function automatic wsc_route_type route_of(
		input wsc_steer_type mode,
		input logic pin,
		input logic [1:0] mode_bits
	);
		route_of = '0;
		unique case (mode)
			WSC_STEER_MODE_BITS: begin
				// The select pin is not looked at in this mode.
				route_of.drive0_on_port = mode_bits[0];
				route_of.drive1_on_port = mode_bits[1];
			end
			WSC_STEER_PIN_SPLIT: begin
				// Inverted: a low pin claims the port.
				route_of.drive0_on_port = 1'b0;
				route_of.drive1_on_port = ~pin;
			end
			WSC_STEER_PIN_BOTH: begin
				route_of.drive0_on_port = ~pin;
				route_of.drive1_on_port = ~pin;
			end
			WSC_STEER_RESERVED: begin
				// Software must not use this code; keep the port for
				// printing so a bad write cannot grab the pins.
				route_of.drive0_on_port = 1'b0;
				route_of.drive1_on_port = 1'b0;
			end
		endcase
		route_of.floppy_on_port = route_of.drive0_on_port |
			route_of.drive1_on_port;
	endfunction

	// Read-back word for one index; bits with no storage stay zero.
	function automatic logic [31:0] read_back(
		input logic [7:0] index,
		input wsc_state_type s
	);
		read_back = 32'h0;
		if (hit(index, `WSC_IDX_SLOW_CLK)) begin
			read_back[`WSC_BIT_ABSENT] = s.absent;
			read_back[`WSC_BIT_KEY_OFF] = s.key_off;
		end else if (hit(index, `WSC_IDX_STEER)) begin
			read_back[`WSC_STEER_MSB:`WSC_STEER_LSB] = s.steer;
		end else if (hit(index, `WSC_IDX_SMB_HIGH)) begin
			read_back[`WSC_HIGH_MSB:0] = s.base_high;
		end else if (hit(index, `WSC_IDX_SMB_LOW)) begin
			read_back[7:`WSC_LOW_LSB] = s.base_low;
		end
	endfunction

	// Applies a lane-0 write; bits with no storage are dropped.
	function automatic wsc_state_type write_into(
		input wsc_state_type s,
		input logic [7:0] index,
		input logic [7:0] data
	);
		write_into = s;
		if (hit(index, `WSC_IDX_SLOW_CLK)) begin
			write_into.absent = data[`WSC_BIT_ABSENT];
			write_into.key_off = data[`WSC_BIT_KEY_OFF];
		end else if (hit(index, `WSC_IDX_STEER)) begin
			write_into.steer = wsc_steer_type'(
				data[`WSC_STEER_MSB:`WSC_STEER_LSB]);
		end else if (hit(index, `WSC_IDX_SMB_HIGH)) begin
			write_into.base_high = data[`WSC_HIGH_MSB:0];
		end else if (hit(index, `WSC_IDX_SMB_LOW)) begin
			write_into.base_low = data[7:`WSC_LOW_LSB];
		end
	endfunction

	always_comb begin
		req.cyc = wb_cyc_i;
		req.stb = wb_stb_i;
		req.we = wb_we_i;
		req.adr = wb_adr_i;
		req.sel = wb_sel_i;
		req.dat = wb_dat_i;
	end

	// Each register takes one aligned word; the index sits in bits 9:2.
	assign idx = req.adr[9:2];
	assign addr_ok = (req.adr[11:10] == 2'h0) && (req.adr[1:0] == 2'h0);
	assign access = req.cyc & req.stb & ~state_q.rsp.ack;
	assign wr_byte0 = access & req.we & req.sel[0] & addr_ok;
	assign base_next = base_of(state_q.base_high, state_q.base_low);

	always_comb begin
		state_d = state_q;

		// One ack per request; it drops the cycle after it is given so a
		// master that holds stb for one more edge is not answered twice.
		state_d.rsp.ack = access;
		state_d.rsp.dat = 32'h0;

		if (access && !req.we && addr_ok) begin
			state_d.rsp.dat = read_back(idx, state_q);
		end

		// Unmapped or misaligned writes are acknowledged and dropped.
		if (wr_byte0) begin
			state_d = write_into(state_d, idx, req.dat[7:0]);
		end

		// The decoded base follows the stored bytes one cycle later.
		state_d.base = base_next;
		state_d.base_ok = (base_next >= `WSC_BASE_MIN) &&
			(base_next <= `WSC_BASE_MAX);

		state_d.route = route_of(state_q.steer, floppy_port_select_pin,
			pp_mode_drive_on_port);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_q.rsp <= '0;
			state_q.absent <= rst_slow_clk[`WSC_BIT_ABSENT];
			state_q.key_off <= rst_slow_clk[`WSC_BIT_KEY_OFF];
			state_q.steer <= wsc_steer_type'(
				rst_steer[`WSC_STEER_MSB:`WSC_STEER_LSB]);
			state_q.base_high <= rst_smb_high[`WSC_HIGH_MSB:0];
			state_q.base_low <= rst_smb_low[7:`WSC_LOW_LSB];
			state_q.base <= 16'h0000;
			state_q.base_ok <= 1'b0;
			state_q.route <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Slow clock is held off while the key logic is off, so that logic
	// sees no edges and burns no switching power.
	wsc_clk_gate wsc_clk_gate_i (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.slow_clock_input(slow_clock_input),
		.gate_on(~state_q.key_off),
		.gated_slow_clock(gated_slow_clock)
	);

	assign wb_ack_o = state_q.rsp.ack;
	assign wb_dat_o = state_q.rsp.dat;
	assign slow_clock_absent_flag = state_q.absent;
	assign wake_key_logic_off = state_q.key_off;
	assign floppy_on_port = state_q.route.floppy_on_port;
	assign drive0_on_port = state_q.route.drive0_on_port;
	assign drive1_on_port = state_q.route.drive1_on_port;
	assign smbus_base_addr = state_q.base;
	assign smbus_base_in_range = state_q.base_ok;

endmodule

`default_nettype wire

// >>> tb/wsc_top_asserts.sv
// Checker for the wake and bus-base register bank.
// Bound to wsc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module wsc_top_asserts (
	input wire logic ref_clk, // Clock.
	input wire logic rst_b, // Reset.
	input wire logic wb_cyc_i, // Cycle.
	input wire logic wb_stb_i, // Strobe.
	input wire logic wb_we_i, // Write.
	input wire logic [11:0] wb_adr_i, // Address.
	input wire logic [3:0] wb_sel_i, // Lanes.
	input wire logic [31:0] wb_dat_i, // Write data.
	input wire logic wb_ack_o, // Ack.
	input wire logic [31:0] wb_dat_o, // Read data.
	input wire logic slow_clock_input, // Slow clock.
	input wire logic slow_clock_absent_flag, // Absent.
	input wire logic wake_key_logic_off, // Key off.
	input wire logic gated_slow_clock, // Gated.
	input wire logic [15:0] smbus_base_addr, // Base.
	input wire logic smbus_base_in_range // In range.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	AST_ACK_NEXT: assert property (req |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_HIGH_ZERO: assert property (wb_dat_o[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	AST_BASE_FIXED: assert property (
		{smbus_base_addr[15:12], smbus_base_addr[2:0]} == 7'h00)
		else $error("fixed base bits not zero");
	AST_RANGE: assert property (
		$past(rst_b) && $stable(smbus_base_addr) |->
		smbus_base_in_range == (smbus_base_addr >= 16'h0100 &&
		smbus_base_addr <= 16'h0ff8))
		else $error("range flag wrong");
	AST_F0_WRITE: assert property (
		req && wb_we_i && wb_sel_i[0] && wb_adr_i == 12'h3c0 |->
		##2 {wake_key_logic_off, slow_clock_absent_flag} ==
		$past(wb_dat_i[1:0], 2))
		else $error("slow clock control not updated");
	AST_F0_READ: assert property (
		req && !wb_we_i && wb_adr_i == 12'h3c0 |=> wb_dat_o ==
		{30'h0, wake_key_logic_off, slow_clock_absent_flag})
		else $error("slow clock control read back wrong");
	AST_LOW_READ: assert property (
		req && !wb_we_i && wb_adr_i == 12'h184 |=>
		wb_dat_o[2:0] == 3'h0)
		else $error("fixed low base bits read back set");
	AST_GATE_OFF: assert property (
		$past(rst_b) && $past(wake_key_logic_off) &&
		wake_key_logic_off |-> !gated_slow_clock)
		else $error("slow clock leaks while off");
	AST_GATE_ON: assert property (
		$past(rst_b) && !$past(wake_key_logic_off) &&
		!wake_key_logic_off |-> gated_slow_clock ==
		$past(slow_clock_input))
		else $error("slow clock blocked while on");
endmodule

bind wsc_top wsc_top_asserts wsc_top_asserts_i (.ref_clk, .rst_b,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .wb_dat_o, .slow_clock_input, .slow_clock_absent_flag,
	.wake_key_logic_off, .gated_slow_clock, .smbus_base_addr,
	.smbus_base_in_range);

`default_nettype wire

// >>> tb/wsc_top_tb.sv
// Self-checking bench for the wake and bus-base register bank.
// Drives every port of wsc_top itself; no partner model.
`timescale 1ns/1ps
`default_nettype none

module wsc_top_tb;
	logic ref_clk = 1'b0, rst_b = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic slow_clock_input = 1'b0, floppy_port_select_pin = 1'b1;
	logic [1:0] pp_mode_drive_on_port = 2'h0;
	logic wb_ack_o, slow_clock_absent_flag, wake_key_logic_off;
	logic gated_slow_clock, floppy_on_port, drive0_on_port, drive1_on_port;
	logic smbus_base_in_range;
	logic [15:0] smbus_base_addr;
	wire logic [2:0] route_out = {floppy_on_port, drive0_on_port,
		drive1_on_port};
	wire logic [22:0] status_out = {slow_clock_absent_flag,
		wake_key_logic_off, gated_slow_clock, route_out,
		smbus_base_in_range, smbus_base_addr};
	integer n_errors = 0, checked = 0;

	always #25 ref_clk = ~ref_clk;

	wsc_top wsc_top_i (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
		.slow_clock_input, .floppy_port_select_pin, .pp_mode_drive_on_port,
		.slow_clock_absent_flag, .wake_key_logic_off, .gated_slow_clock,
		.floppy_on_port, .drive0_on_port, .drive1_on_port, .smbus_base_addr,
		.smbus_base_in_range);

	task give_verdict;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds the request until ack is sampled; one idle cycle follows.
	task bus(input logic w, input logic [11:0] a, input logic [3:0] s,
		input logic [31:0] d);
		integer k;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (wb_ack_o !== 1'b1) begin
			chk({31'h0, wb_ack_o}, 32'h1);
			give_verdict;
		end else begin
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, 4'h1, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 4'hf, 32'h0);
		chk(q, e);
	endtask

	// The expected value e is {in-range flag, base address}.
	task base_case(input logic [7:0] h, input logic [7:0] l,
		input logic [16:0] e);
		wr(12'h180, {24'h0, h});
		wr(12'h184, {24'h0, l});
		repeat (2) @(posedge ref_clk);
		chk(status_out[16:0], {15'h0, e});
	endtask

	function automatic logic [2:0] route(input logic [1:0] m,
		input logic p, input logic [1:0] pp);
		logic [1:0] d;
		case (m)
			2'h0: d = {pp[0], pp[1]};
			2'h1: d = {1'b0, ~p};
			2'h2: d = {~p, ~p};
			default: d = 2'h0;
		endcase
		return {|d, d};
	endfunction

	// Serves both the start of the run and a reset in mid-run; the pins
	// are parked first so the first two edges after release read zero.
	task test_reset;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		slow_clock_input <= 1'b0;
		floppy_port_select_pin <= 1'b1;
		pp_mode_drive_on_port <= 2'h0;
		repeat (11) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk(status_out, 32'h0);
		@(posedge ref_clk);
		chk(status_out, 32'h0);
		rd(12'h180, 32'h0);
		rd(12'h184, 32'h0);
		rd(12'h3c0, 32'h0);
		rd(12'h3c4, 32'h0);
		$display("test reset done");
	endtask

	task test_base;
		base_case(8'hff, 8'hff, {1'b1, 16'h0ff8});
		rd(12'h180, 32'h0f);
		rd(12'h184, 32'hf8);
		base_case(8'h00, 8'h0f, {1'b0, 16'h0008});
		base_case(8'h00, 8'hff, {1'b0, 16'h00f8});
		base_case(8'h01, 8'h07, {1'b1, 16'h0100});
		$display("test base done");
	endtask

	task test_wake;
		wr(12'h3c0, 32'hff);
		rd(12'h3c0, 32'h03);
		slow_clock_input <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(status_out[22:20], 32'h6);
		wr(12'h3c0, 32'h00);
		repeat (3) @(posedge ref_clk);
		chk(gated_slow_clock, 1'b1);
		slow_clock_input <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(gated_slow_clock, 1'b0);
		wr(12'h3c0, 32'h01);
		chk(status_out[22:21], 32'h2);
		bus(1'b1, 12'h3c0, 4'he, 32'hfe);
		rd(12'h3c0, 32'h01);
		$display("test wake done");
	endtask

	task test_steering;
		for (int m = 0; m < 4; m++) begin
			wr(12'h3c4, 32'hfc | 32'(m));
			rd(12'h3c4, 32'(m));
			for (int p = 0; p < 8; p++) begin
				floppy_port_select_pin <= p[2];
				pp_mode_drive_on_port <= p[1:0];
				repeat (3) @(posedge ref_clk);
				chk(route_out, route(m[1:0], p[2], p[1:0]));
			end
		end
		$display("test steering done");
	endtask

	// Index bits 9:2 of 0xd80 and 0x181 match the base high byte, but addr_ok rejects both.
	task test_unmapped;
		wr(12'h3c8, 32'hff);
		rd(12'h3c8, 32'h0);
		rd(12'h181, 32'h0);
		rd(12'hd80, 32'h0);
		wr(12'hd80, 32'hff);
		wr(12'h181, 32'hff);
		rd(12'h180, 32'h01);
		$display("test unmapped done");
	endtask

	initial begin
		test_reset;
		test_base;
		test_wake;
		test_steering;
		test_unmapped;
		test_reset;
		give_verdict;
	end
endmodule

`default_nettype wire
